// >>> pkg/pin_select_map.svh
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PSEL_P01_INDEX      18'h0a051
`define PSEL_P02_INDEX      18'h0a052
`define PSEL_P03_INDEX      18'h0a053
`define PSEL_P04_INDEX      18'h0a054
`define PSEL_P05_INDEX      18'h0a055
`define PSEL_P06_INDEX      18'h0a056
`define PSEL_P07_INDEX      18'h0a057
`define PSEL_P10_INDEX      18'h0a058
`define PSEL_P11_INDEX      18'h0a059
`define PSEL_P12_INDEX      18'h0a05a
`define PSEL_FIRST_INDEX    `PSEL_P01_INDEX
`define PSEL_LAST_INDEX     `PSEL_P12_INDEX
`define PSEL_STATUS_INDEX   18'h0a0e0

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define SEL_GPIO_BIT        0
`define SEL_FUNC1_BIT       1
`define SEL_FUNC2_BIT       2
`define SEL_EDGE_BIT        3
`define SEL_RESET           8'h00
`define SEL_MASK_IRQ_PIN    8'h0f
`define SEL_MASK_OTHER      8'h07
`define STATUS_RESET        32'h0000_0000

// ----------------------------------------------------------------------------
// Pin slots
// ----------------------------------------------------------------------------
`define PIN_COUNT           10
`define IRQ_PIN_COUNT       5
`define ANALOG_COUNT        9
`define PIN_P01             0
`define PIN_P06             5
`define PIN_P07             6
`define PIN_P10             7
`define PIN_P11             8
`define PIN_P12             9

`endif

// >>> pkg/pin_select_pkg.sv
package pin_select_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [19:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_type;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_type;

    typedef enum logic [1:0] {
        ROUTE_NONE,
        ROUTE_GPIO,
        ROUTE_FUNC1,
        ROUTE_FUNC2
    } route_kind_type;

endpackage

// >>> verilog/select_reg_bank.sv
`timescale 1ns/1ps
`include "pin_select_map.svh"

module select_reg_bank #(
    parameter int DEPTH = `PIN_COUNT,
    parameter int WIDTH = 8,
    parameter int SLOTW = $clog2(DEPTH)
) (
    input  wire logic                        clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        wr_en_i,
    input  wire logic [SLOTW-1:0]            wr_slot_i,
    input  wire logic [WIDTH-1:0]            wr_data_i,
    input  wire logic [SLOTW-1:0]            rd_slot_i,
    output logic      [WIDTH-1:0]            rd_data_o,
    output logic      [DEPTH-1:0][WIDTH-1:0] contents_o
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0]            rdata;
    } bank_state_type;

    bank_state_type st_reg;
    bank_state_type st_next;

    always_comb begin
        st_next = st_reg;
        if (wr_en_i && (int'(wr_slot_i) < DEPTH)) begin
            st_next.cells[wr_slot_i] = wr_data_i;
        end
        // Read port ignores a same-cycle write; the bus never reads and writes at once
        st_next.rdata = (int'(rd_slot_i) < DEPTH) ? st_reg.cells[rd_slot_i] : '0;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_o  = st_reg.rdata;
    assign contents_o = st_reg.cells;

endmodule

// >>> verilog/pin_function_select.sv
`timescale 1ns/1ps
`include "pin_select_map.svh"

module pin_function_select (
    input  wire logic                                clk_i,
    input  wire logic                                resetn_i,
    input  wire pin_select_pkg::apb_req_type         apb_req_i,
    output pin_select_pkg::apb_rsp_type              apb_rsp_o,
    input  wire logic [`PIN_COUNT-1:0]               pad_in_i,
    input  wire logic [`PIN_COUNT-1:0]               pad_analog_mux_enable_i,
    input  wire logic [`PIN_COUNT-1:0]               gpio_out_i,
    input  wire logic [`PIN_COUNT-1:0]               gpio_oe_n_i,
    input  wire logic                                uart0_txd_i,
    input  wire logic [1:0]                          counter_array_out_i,
    input  wire logic [1:0]                          counter_array_oe_n_i,
    input  wire logic                                i2c_master_sda_out_i,
    input  wire logic                                i2c_master_sda_oe_n_i,
    input  wire logic                                i2c_slave_sda_out_i,
    input  wire logic                                i2c_slave_sda_oe_n_i,
    output logic      [`PIN_COUNT-1:0]               pad_out_o,
    output logic      [`PIN_COUNT-1:0]               pad_oe_n_o,
    output logic      [`PIN_COUNT-1:0]               gpio_in_o,
    output logic      [`IRQ_PIN_COUNT-1:0]           group1_pin_irq_o,
    output logic      [`ANALOG_COUNT-1:0]            analog_route_o,
    output logic                                     uart0_rxd_o,
    output logic      [1:0]                          counter_array_in_o,
    output logic                                     i2c_master_sda_in_o,
    output logic                                     i2c_slave_sda_in_o
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
        logic [`PIN_COUNT-1:0]     pad_prev;
        logic [`PIN_COUNT-1:0]     pad_out;
        logic [`PIN_COUNT-1:0]     pad_oe_n;
        logic [`PIN_COUNT-1:0]     gpio_in;
        logic [`IRQ_PIN_COUNT-1:0] irq;
        logic [`ANALOG_COUNT-1:0]  analog;
        logic                      uart_rxd;
        logic [1:0]                cex_in;
        logic                      msda_in;
        logic                      ssda_in;
    } core_state_type;

    core_state_type                       st_reg;
    core_state_type                       st_next;
    logic [`PIN_COUNT-1:0][7:0]           sel_regs;
    logic [7:0]                           rd_byte;
    logic [17:0]                          req_index;
    logic                                 hit_pin;
    logic                                 hit_status;
    logic [3:0]                           req_slot;
    logic                                 access;
    logic                                 wr_commit;
    logic [7:0]                           wr_byte;
    logic [`PIN_COUNT-1:0]                conflict;
    pin_select_pkg::route_kind_type       route_sel [`PIN_COUNT];

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Peripheral bits outrank general I/O so a bad setting still routes one source
    function automatic pin_select_pkg::route_kind_type pick_function(input logic [7:0] sel);
        if (sel[`SEL_FUNC2_BIT]) begin
            return pin_select_pkg::ROUTE_FUNC2;
        end else if (sel[`SEL_FUNC1_BIT]) begin
            return pin_select_pkg::ROUTE_FUNC1;
        end else if (sel[`SEL_GPIO_BIT]) begin
            return pin_select_pkg::ROUTE_GPIO;
        end
        return pin_select_pkg::ROUTE_NONE;
    endfunction

    function automatic logic [7:0] slot_mask(input logic [3:0] slot);
        return (int'(slot) < `IRQ_PIN_COUNT) ? `SEL_MASK_IRQ_PIN : `SEL_MASK_OTHER;
    endfunction

    function automatic logic multi_select(input logic [7:0] sel);
        return (sel[`SEL_GPIO_BIT] & sel[`SEL_FUNC1_BIT]) | (sel[`SEL_GPIO_BIT] & sel[`SEL_FUNC2_BIT])
             | (sel[`SEL_FUNC1_BIT] & sel[`SEL_FUNC2_BIT]);
    endfunction

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    select_reg_bank #(
        .DEPTH      (`PIN_COUNT),
        .WIDTH      (8)
    ) u_bank (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .wr_en_i    (wr_commit),
        .wr_slot_i  (req_slot),
        .wr_data_i  (wr_byte),
        .rd_slot_i  (req_slot),
        .rd_data_o  (rd_byte),
        .contents_o (sel_regs)
    );

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    assign req_index  = apb_req_i.paddr[19:2];
    assign hit_pin    = (apb_req_i.paddr[1:0] == 2'h0) && (req_index >= `PSEL_FIRST_INDEX)
                        && (req_index <= `PSEL_LAST_INDEX);
    assign hit_status = (apb_req_i.paddr[1:0] == 2'h0) && (req_index == `PSEL_STATUS_INDEX);
    assign req_slot   = hit_pin ? 4'(req_index - `PSEL_FIRST_INDEX) : 4'hf;
    assign access     = apb_req_i.psel && apb_req_i.penable;
    // Write lands at the edge where pready is seen high; lanes above byte 0 do not exist
    assign wr_commit  = access && st_reg.pready && apb_req_i.pwrite && hit_pin && apb_req_i.pstrb[0];
    assign wr_byte    = apb_req_i.pwdata[7:0] & slot_mask(req_slot);

    // ------------------------------------------------------------------------
    // Routing and next state
    // ------------------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < `PIN_COUNT; p++) begin
            route_sel[p] = pick_function(sel_regs[p]);
            conflict[p]  = multi_select(sel_regs[p]);
        end

        st_next          = st_reg;
        st_next.pad_prev = pad_in_i;

        if (access && !st_reg.pready) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = !(hit_pin || hit_status);
            if (hit_pin) begin
                st_next.prdata = {24'h00_0000, rd_byte};
            end else if (hit_status) begin
                st_next.prdata = {22'h00_0000, conflict};
            end else begin
                st_next.prdata = 32'h0000_0000;
            end
        end else begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
        end

        st_next.pad_out  = '0;
        st_next.pad_oe_n = '1;
        st_next.gpio_in  = '0;
        st_next.irq      = '0;
        st_next.analog   = '0;
        st_next.uart_rxd = 1'b1;
        st_next.cex_in   = 2'h0;
        st_next.msda_in  = 1'b1;
        st_next.ssda_in  = 1'b1;

        for (int p = 0; p < `PIN_COUNT; p++) begin
            case (route_sel[p])
                pin_select_pkg::ROUTE_GPIO: begin
                    st_next.gpio_in[p]  = pad_in_i[p];
                    st_next.pad_out[p]  = gpio_out_i[p];
                    st_next.pad_oe_n[p] = gpio_oe_n_i[p];
                end
                default: begin
                end
            endcase
        end

        // Pins 0.1-0.5 are inputs only in their peripheral roles
        for (int p = 0; p < `IRQ_PIN_COUNT; p++) begin
            case (route_sel[p])
                pin_select_pkg::ROUTE_FUNC1: begin
                    if (sel_regs[p][`SEL_EDGE_BIT]) begin
                        st_next.irq[p] = pad_in_i[p] && !st_reg.pad_prev[p];
                    end else begin
                        st_next.irq[p] = !pad_in_i[p] && st_reg.pad_prev[p];
                    end
                end
                pin_select_pkg::ROUTE_FUNC2: begin
                    st_next.analog[p] = pad_analog_mux_enable_i[p];
                end
                default: begin
                end
            endcase
        end

        case (route_sel[`PIN_P06])
            pin_select_pkg::ROUTE_FUNC1: begin
                st_next.pad_out[`PIN_P06]  = uart0_txd_i;
                st_next.pad_oe_n[`PIN_P06] = 1'b0;
            end
            pin_select_pkg::ROUTE_FUNC2: begin
                st_next.analog[`PIN_P06] = pad_analog_mux_enable_i[`PIN_P06];
            end
            default: begin
            end
        endcase

        case (route_sel[`PIN_P07])
            pin_select_pkg::ROUTE_FUNC1: begin
                st_next.uart_rxd = pad_in_i[`PIN_P07];
            end
            pin_select_pkg::ROUTE_FUNC2: begin
                st_next.analog[`PIN_P07] = pad_analog_mux_enable_i[`PIN_P07];
            end
            default: begin
            end
        endcase

        case (route_sel[`PIN_P10])
            pin_select_pkg::ROUTE_FUNC2: begin
                st_next.pad_out[`PIN_P10]  = counter_array_out_i[0];
                st_next.pad_oe_n[`PIN_P10] = counter_array_oe_n_i[0];
                st_next.cex_in[0]          = pad_in_i[`PIN_P10];
            end
            pin_select_pkg::ROUTE_FUNC1: begin
                st_next.analog[`PIN_P10] = pad_analog_mux_enable_i[`PIN_P10];
            end
            default: begin
            end
        endcase

        case (route_sel[`PIN_P11])
            pin_select_pkg::ROUTE_FUNC2: begin
                st_next.pad_out[`PIN_P11]  = counter_array_out_i[1];
                st_next.pad_oe_n[`PIN_P11] = counter_array_oe_n_i[1];
                st_next.cex_in[1]          = pad_in_i[`PIN_P11];
            end
            pin_select_pkg::ROUTE_FUNC1: begin
                st_next.analog[`PIN_P11] = pad_analog_mux_enable_i[`PIN_P11];
            end
            default: begin
            end
        endcase

        // Data line passes drive and enable through; open-drain is the pad's business
        case (route_sel[`PIN_P12])
            pin_select_pkg::ROUTE_FUNC2: begin
                st_next.pad_out[`PIN_P12]  = i2c_master_sda_out_i;
                st_next.pad_oe_n[`PIN_P12] = i2c_master_sda_oe_n_i;
                st_next.msda_in            = pad_in_i[`PIN_P12];
            end
            pin_select_pkg::ROUTE_FUNC1: begin
                st_next.pad_out[`PIN_P12]  = i2c_slave_sda_out_i;
                st_next.pad_oe_n[`PIN_P12] = i2c_slave_sda_oe_n_i;
                st_next.ssda_in            = pad_in_i[`PIN_P12];
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg          <= '0;
            st_reg.pad_oe_n <= '1;
            st_reg.uart_rxd <= 1'b1;
            st_reg.msda_in  <= 1'b1;
            st_reg.ssda_in  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign apb_rsp_o.pready   = st_reg.pready;
    assign apb_rsp_o.prdata   = st_reg.prdata;
    assign apb_rsp_o.pslverr  = st_reg.pslverr;
    assign pad_out_o          = st_reg.pad_out;
    assign pad_oe_n_o         = st_reg.pad_oe_n;
    assign gpio_in_o          = st_reg.gpio_in;
    assign group1_pin_irq_o   = st_reg.irq;
    assign analog_route_o     = st_reg.analog;
    assign uart0_rxd_o        = st_reg.uart_rxd;
    assign counter_array_in_o = st_reg.cex_in;
    assign i2c_master_sda_in_o = st_reg.msda_in;
    assign i2c_slave_sda_in_o = st_reg.ssda_in;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_reset_clears: assert property (disable iff (1'b0) !resetn_i |=> (sel_regs == '0))
        else $error("selection registers not cleared by reset");

    chk_write_lands: assert property (wr_commit |=> sel_regs[$past(req_slot)] == $past(wr_byte))
        else $error("written byte not stored");

    chk_upper_zero: assert property (sel_regs[`PIN_P06][7:3] == 5'h00 && sel_regs[`PIN_P01][7:4] == 4'h0)
        else $error("unused selection bits became set");

    chk_bus_answer: assert property ((access && !st_reg.pready) |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
        else $error("bus answer not after one wait state");

    chk_gpio_pass: assert property ((route_sel[`PIN_P01] == pin_select_pkg::ROUTE_GPIO)
        |=> gpio_in_o[`PIN_P01] == $past(pad_in_i[`PIN_P01]))
        else $error("general I/O input not passed");

    chk_irq_rising: assert property ((route_sel[`PIN_P01] == pin_select_pkg::ROUTE_FUNC1)
        && sel_regs[`PIN_P01][`SEL_EDGE_BIT] && $rose(pad_in_i[`PIN_P01]) |=> group1_pin_irq_o[`PIN_P01])
        else $error("rising edge interrupt missed");

    chk_irq_quiet: assert property ((route_sel[`PIN_P01] != pin_select_pkg::ROUTE_FUNC1)
        |=> !group1_pin_irq_o[`PIN_P01])
        else $error("interrupt raised while not routed");

    chk_analog_gate: assert property (analog_route_o[`PIN_P07] == $past(pad_analog_mux_enable_i[`PIN_P07]
        && route_sel[`PIN_P07] == pin_select_pkg::ROUTE_FUNC2))
        else $error("analog route not gated by pad enable");

    chk_uart_tx: assert property ((route_sel[`PIN_P06] == pin_select_pkg::ROUTE_FUNC1)
        |=> !pad_oe_n_o[`PIN_P06] && pad_out_o[`PIN_P06] == $past(uart0_txd_i))
        else $error("transmit not driven on pin");

    chk_rx_idle: assert property ((route_sel[`PIN_P07] != pin_select_pkg::ROUTE_FUNC1) |=> uart0_rxd_o)
        else $error("receive line not idle when unrouted");

    chk_cex_wins: assert property (sel_regs[`PIN_P10][`SEL_FUNC2_BIT] && sel_regs[`PIN_P10][`SEL_GPIO_BIT]
        |=> pad_out_o[`PIN_P10] == $past(counter_array_out_i[0]) && gpio_in_o[`PIN_P10] == 1'b0)
        else $error("counter channel did not outrank general I/O");

    chk_i2c_master: assert property ((route_sel[`PIN_P12] == pin_select_pkg::ROUTE_FUNC2)
        |=> pad_oe_n_o[`PIN_P12] == $past(i2c_master_sda_oe_n_i) && i2c_slave_sda_in_o)
        else $error("master data line not routed");

endmodule

// >>> sim/periph_model.sv
`timescale 1ns/1ps

module periph_model (
    input  wire logic       level_i,
    output logic      [9:0] gpio_out_o,
    output logic      [9:0] gpio_oe_n_o,
    output logic            uart0_txd_o,
    output logic      [1:0] counter_out_o,
    output logic      [1:0] counter_oe_n_o,
    output logic            master_sda_out_o,
    output logic            master_sda_oe_n_o,
    output logic            slave_sda_out_o,
    output logic            slave_sda_oe_n_o
);
    // Odd per-pin pattern, so a swapped route shows up
    assign gpio_out_o        = {10{level_i}} ^ 10'h155;
    assign gpio_oe_n_o       = 10'h000;
    assign uart0_txd_o       = level_i;
    assign counter_out_o     = {level_i, ~level_i};
    assign counter_oe_n_o    = 2'b00;
    // Data lines only ever pull low, the pull-up gives the high
    assign master_sda_out_o  = 1'b0;
    assign master_sda_oe_n_o = level_i;
    assign slave_sda_out_o   = 1'b0;
    assign slave_sda_oe_n_o  = ~level_i;
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end

module tb_top;
    logic                        clk_i = 1'b0;
    logic                        resetn_i = 1'b0;
    logic                        level = 1'b0;
    logic [9:0]                  ext = 10'h200;
    logic [9:0]                  pad_analog_mux_enable_i = 10'h000;
    logic [9:0]                  pad_in_i, gpio_out_i, gpio_oe_n_i, pad_out_o, pad_oe_n_o, gpio_in_o;
    logic                        uart0_txd_i, uart0_rxd_o, i2c_master_sda_in_o, i2c_slave_sda_in_o;
    logic                        i2c_master_sda_out_i, i2c_master_sda_oe_n_i;
    logic                        i2c_slave_sda_out_i, i2c_slave_sda_oe_n_i;
    logic [1:0]                  counter_array_out_i, counter_array_oe_n_i, counter_array_in_o;
    logic [4:0]                  group1_pin_irq_o;
    logic [4:0]                  seen;
    logic [8:0]                  analog_route_o;
    logic [31:0]                 rd;
    logic                        er;
    pin_select_pkg::apb_req_type apb_req_i = '0;
    pin_select_pkg::apb_rsp_type apb_rsp_o;
    int                          err_count = 0;
    int                          compares = 0;

    always #4 clk_i = ~clk_i;
    // Undriven pins follow the outside level; pin 9 has a pull-up
    assign pad_in_i = (pad_oe_n_o & ext) | (~pad_oe_n_o & pad_out_o);

    pin_function_select i_dut (.clk_i, .resetn_i, .apb_req_i, .apb_rsp_o, .pad_in_i,
        .pad_analog_mux_enable_i, .gpio_out_i, .gpio_oe_n_i, .uart0_txd_i, .counter_array_out_i,
        .counter_array_oe_n_i, .i2c_master_sda_out_i, .i2c_master_sda_oe_n_i, .i2c_slave_sda_out_i,
        .i2c_slave_sda_oe_n_i, .pad_out_o, .pad_oe_n_o, .gpio_in_o, .group1_pin_irq_o,
        .analog_route_o, .uart0_rxd_o, .counter_array_in_o, .i2c_master_sda_in_o, .i2c_slave_sda_in_o);

    periph_model i_periph (.level_i(level), .gpio_out_o(gpio_out_i), .gpio_oe_n_o(gpio_oe_n_i),
        .uart0_txd_o(uart0_txd_i), .counter_out_o(counter_array_out_i),
        .counter_oe_n_o(counter_array_oe_n_i), .master_sda_out_o(i2c_master_sda_out_i),
        .master_sda_oe_n_o(i2c_master_sda_oe_n_i), .slave_sda_out_o(i2c_slave_sda_out_i),
        .slave_sda_oe_n_o(i2c_slave_sda_oe_n_i));

    // ------------------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------------------
    // Slot -1 lands on the unmapped word just below the first register
    // Waits for pready without a limit of its own; the watchdog ends a hang
    task automatic apb(input logic w, input int s, input logic [31:0] d);
        @(posedge clk_i);
        apb_req_i <= '{1'b1, 1'b0, w, 20'h28144 + 20'(4 * s), d, 4'hf};
        @(posedge clk_i);
        apb_req_i.penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (apb_rsp_o.pready !== 1'b1);
        rd = apb_rsp_o.prdata;
        er = apb_rsp_o.pslverr;
        apb_req_i <= '0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic clr();
        for (int s = 0; s < 10; s++) apb(1'b1, s, 32'h0);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_regs();
        for (int s = 0; s < 10; s++) begin
            apb(1'b0, s, 32'h0);
            `CHK(rd, 32'h0)
            `CHK(er, 1'b0)
            apb(1'b1, s, 32'hffff_ffff);
            apb(1'b0, s, 32'h0);
            `CHK(rd, (s < 5) ? 32'h0f : 32'h07)
        end
        clr();
        apb(1'b0, -1, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b0, 10, 32'h0);
        `CHK(er, 1'b1)
    endtask

    task automatic t_gpio();
        for (int s = 0; s < 10; s++) apb(1'b1, s, 32'h01);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            level <= k[0];
            settle();
            `CHK(pad_out_o, {10{k[0]}} ^ 10'h155)
            `CHK(pad_oe_n_o, 10'h000)
            `CHK(gpio_in_o, {10{k[0]}} ^ 10'h155)
        end
        clr();
    endtask

    task automatic t_irq();
        for (int i = 0; i < 5; i++) begin
            for (int m = 0; m < 3; m++) begin
                apb(1'b1, i, (m == 0) ? 32'h0a : (m == 1) ? 32'h02 : 32'h08);
                @(posedge clk_i);
                ext[i] <= ~ext[i];
                seen = 5'h00;
                repeat (4) begin
                    @(posedge clk_i);
                    #1;
                    seen |= group1_pin_irq_o;
                end
                `CHK(seen, (m < 2) ? 5'(1 << i) : 5'h00)
            end
            apb(1'b1, i, 32'h0);
            @(posedge clk_i);
            ext[i] <= 1'b0;
        end
    endtask

    task automatic t_analog();
        for (int s = 0; s < 9; s++) begin
            @(posedge clk_i);
            pad_analog_mux_enable_i <= 10'h3ff;
            apb(1'b1, s, (s < 7) ? 32'h04 : 32'h02);
            settle();
            `CHK(analog_route_o, 9'(1 << s))
            @(posedge clk_i);
            pad_analog_mux_enable_i <= 10'h000;
            settle();
            `CHK(analog_route_o, 9'h000)
            apb(1'b1, s, 32'h0);
        end
    endtask

    task automatic t_periph();
        apb(1'b1, 5, 32'h02);
        apb(1'b1, 6, 32'h02);
        apb(1'b1, 7, 32'h04);
        apb(1'b1, 8, 32'h04);
        apb(1'b1, 9, 32'h07);
        // Own status word sits 8'h8f slots above the first register
        apb(1'b0, 8'h8f, 32'h0);
        `CHK(rd, 32'h0000_0200)
        `CHK(er, 1'b0)
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            level <= k[0];
            ext <= {1'b1, {9{~k[0]}}};
            settle();
            `CHK(pad_out_o[5], k[0])
            `CHK(pad_oe_n_o[5], 1'b0)
            `CHK(uart0_rxd_o, ~k[0])
            `CHK(counter_array_in_o, {k[0], ~k[0]})
            `CHK(pad_oe_n_o[9], k[0])
            `CHK(i2c_master_sda_in_o, k[0])
            `CHK(i2c_slave_sda_in_o, 1'b1)
        end
        apb(1'b1, 9, 32'h02);
        settle();
        `CHK(i2c_slave_sda_in_o, 1'b0)
        `CHK(i2c_master_sda_in_o, 1'b1)
    endtask

    task automatic test_done();
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_gpio();
        t_irq();
        t_analog();
        t_periph();
        test_done();
    end

    initial begin
        #100us;
        err_count++;
        test_done();
    end
endmodule
